//--- src/adcms_sequencer.sv
// Purpose: Five-channel monitor converter sequencer with result registers
// Assumes: Front end answers every start with one done pulse and a code
// Notes: Calibration store has no reset, as it models nonvolatile memory
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// R1: Five channels converted in turn, a fresh round every conversion interval.
// R2: Voltage slot follows the aux select only in OEM mode, else input supply.
// R3: Three-bit aux select in config register 0 picks one of seven nodes.
// R4: Bias current result: code in high byte, low byte always zero.
// R5: Transmit power result: code in high byte, low byte always zero.
// R6: Photodiode input referenced to ground or analog supply by polarity bit.
// R7: Temperature and supply results stored as calibrated two-byte values.
// R8: Calibration constants kept in a host-readable store, writable in OEM mode.
// R9: Host should store unity slopes and zero offsets for voltage and temperature.
// R10: Host finds bias offset with transmitter off and stores its negative.
// R11: Latest results readable by the host at any time at 60h to 69h.
// R12: Read-only data-ready flag per channel set when a new result lands.
// R13: Both bytes of a result are written together when the conversion ends.
module adcms_sequencer #(
  parameter int CONV_INTERVAL_US = 100
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [adcms_pkg::ADDR_W-1:0] i_addr,
  input wire logic [adcms_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [adcms_pkg::DATA_W-1:0] o_rdata,
  output adcms_pkg::adcms_conv_req_s o_conv_req,
  input wire adcms_pkg::adcms_conv_rsp_s i_conv_rsp,
  output logic [adcms_pkg::NUM_CHAN-1:0] o_data_ready
);
  import adcms_pkg::*;

  // Interval length in cycles, rounded down
  localparam int CONV_CYCLES = (CONV_INTERVAL_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam logic [2:0] LAST_CHAN = 3'(NUM_CHAN - 1);
  localparam logic [2:0] CHAN_STEP = 3'h1;

  // Maps an address in a window to a byte index from its base
  // Only the low six bits are kept, as no window is wider than 64 bytes
  function automatic logic [5:0] offset_of(input logic [8:0] addr, input logic [8:0] base);
    logic [8:0] diff;
    diff = addr - base;
    offset_of = diff[5:0];
  endfunction

  // True when the address falls in a window
  // Both bounds count as inside the window
  function automatic logic in_window(input logic [8:0] addr, input logic [8:0] lo, input logic [8:0] hi);
    in_window = (addr >= lo) && (addr <= hi);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Interval divider

  logic interval_tick;

  // The interval must outlast one round, or ticks that come while busy
  // collapse into a single pending round and a round is lost
  adcms_tick_gen #(
    .PERIOD_CYCLES(CONV_CYCLES)
  ) adcms_tick_gen_i (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .o_tick(interval_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] oem_config_reg0;
  logic [7:0] oem_config_reg1;
  logic oem_mode;
  logic [7:0] next_oem_config_reg0;
  logic [7:0] next_oem_config_reg1;
  logic next_oem_mode;
  logic [AUX_SEL_W-1:0] aux_source_select;
  logic bias_reference_polarity;

  assign aux_source_select = oem_config_reg0[AUX_SEL_LSB +: AUX_SEL_W]; // R3
  assign bias_reference_polarity = oem_config_reg1[BIAS_REF_BIT];

  // OEM mode gates both the voltage-slot redirect and calibration writes;
  // it resets off so a fresh device always measures the input supply
  // Host writes to the configuration registers; other OEM page bytes ignored
  always_comb begin
    next_oem_config_reg0 = oem_config_reg0;
    next_oem_config_reg1 = oem_config_reg1;
    next_oem_mode = oem_mode;
    if (i_wr) begin
      if (i_addr == ADDR_OEM_CFG0) begin
        next_oem_config_reg0 = i_wdata;
      end else if (i_addr == ADDR_OEM_CFG1) begin
        next_oem_config_reg1 = i_wdata;
      end else if (i_addr == ADDR_OEM_MODE) begin
        next_oem_mode = i_wdata[OEM_MODE_BIT];
      end
    end
  end

  // Register the configuration
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      oem_config_reg0 <= OEM_CFG0_RESET;
      oem_config_reg1 <= OEM_CFG1_RESET;
      oem_mode <= 1'b0;
    end else begin
      oem_config_reg0 <= next_oem_config_reg0;
      oem_config_reg1 <= next_oem_config_reg1;
      oem_mode <= next_oem_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Calibration constant store

  logic [7:0] cal_mem [CAL_BYTES];
  logic cal_hit_wr;

  assign cal_hit_wr = i_wr && oem_mode && in_window(i_addr, ADDR_CAL_FIRST, ADDR_CAL_LAST);

  // Addresses outside the window never reach the array, so the index
  // taken from the window base always stays inside the store
  // Writable only in OEM mode; no reset so contents persist
  always_ff @(posedge i_clock) begin
    if (cal_hit_wr) begin
      cal_mem[offset_of(i_addr, ADDR_CAL_FIRST)] <= i_wdata; // R8
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  adcms_seq_e state;
  adcms_seq_e next_state;
  logic [2:0] slot;
  logic [2:0] next_slot;
  logic round_pending;
  logic next_round_pending;
  adcms_conv_req_s next_conv_req;
  logic result_we;
  adcms_aux_e aux_choice;

  // Voltage slot source: aux select only in OEM mode, code 111 falls back
  // Code 111 names no node, so no request ever carries it
  always_comb begin
    aux_choice = AUX_INPUT_SUPPLY; // R2
    if (oem_mode && (aux_source_select != 3'h7)) begin
      aux_choice = adcms_aux_e'(aux_source_select); // R2 R3
    end
  end

  // IDLE waits for a round, START issues one request, WAIT holds for done;
  // the next slot is requested two cycles after the previous answer
  // There is no timeout: a front end that drops a done stalls the round,
  // and later ticks only leave one round pending
  // Step through the five slots once per interval
  always_comb begin
    next_state = state;
    next_slot = slot;
    next_round_pending = round_pending || interval_tick;
    next_conv_req = o_conv_req;
    next_conv_req.start = 1'b0;
    result_we = 1'b0;
    case (state)
      SEQ_IDLE: begin
        if (round_pending || interval_tick) begin
          next_round_pending = 1'b0;
          next_slot = 3'h0;
          next_state = SEQ_START; // R1
        end
      end
      SEQ_START: begin
        next_conv_req.start = 1'b1;
        next_conv_req.chan = adcms_chan_e'(slot); // R1
        next_conv_req.aux = aux_choice;
        next_conv_req.ref_to_supply = bias_reference_polarity; // R6
        next_state = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (i_conv_rsp.done) begin
          result_we = 1'b1;
          if (slot == LAST_CHAN) begin
            next_state = SEQ_IDLE;
          end else begin
            next_slot = slot + CHAN_STEP;
            next_state = SEQ_START; // R1
          end
        end
      end
      default: begin
        next_state = SEQ_IDLE;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= SEQ_IDLE;
      slot <= 3'h0;
      round_pending <= 1'b1;
      o_conv_req <= '{start: 1'b0, chan: CHAN_TEMP, aux: AUX_INPUT_SUPPLY, ref_to_supply: 1'b0};
    end else begin
      state <= next_state;
      slot <= next_slot;
      round_pending <= next_round_pending;
      o_conv_req <= next_conv_req;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result registers and data-ready flags

  logic [15:0] result [NUM_CHAN];
  logic [15:0] next_word;
  logic [NUM_CHAN-1:0] next_ready;
  logic flags_read;

  // Code in the high byte, low byte zero: for temperature 1 degree per step
  // and for supply 100 uV units, this is already the calibrated format
  assign next_word = {i_conv_rsp.code, LOW_BYTE_ZERO}; // R4 R5 R7
  assign flags_read = i_rd && (i_addr == ADDR_DATA_READY);

  // Flag set on a new result wins over a clear by reading the flags
  always_comb begin
    next_ready = o_data_ready;
    if (flags_read) begin
      next_ready = '0;
    end
    if (result_we) begin
      next_ready[slot] = 1'b1; // R12
    end
  end

  // Results reset to zero so a read before the first round is defined
  // Both bytes of a channel update in the same edge
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        result[i] <= '0;
      end
      o_data_ready <= '0;
    end else begin
      if (result_we) begin
        result[slot] <= next_word; // R13
      end
      o_data_ready <= next_ready;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [7:0] next_rdata;
  logic [5:0] res_off;
  logic [5:0] cal_off;

  assign res_off = offset_of(i_addr, ADDR_RESULT_FIRST);
  assign cal_off = offset_of(i_addr, ADDR_CAL_FIRST);

  // Writes are never decoded here, so results and flags stay read-only
  // Decode reads; results big-endian, unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (!i_rd) begin
      next_rdata = 8'h00;
    end else if (in_window(i_addr, ADDR_RESULT_FIRST, ADDR_RESULT_LAST)) begin
      if (res_off[0]) begin
        next_rdata = result[res_off[3:1]][7:0]; // R11 R4 R5
      end else begin
        next_rdata = result[res_off[3:1]][15:8]; // R11
      end
    end else if (in_window(i_addr, ADDR_CAL_FIRST, ADDR_CAL_LAST)) begin
      next_rdata = cal_mem[cal_off]; // R8
    end else if (i_addr == ADDR_DATA_READY) begin
      next_rdata = {3'h0, o_data_ready}; // R12
    end else if (i_addr == ADDR_OEM_CFG0) begin
      next_rdata = oem_config_reg0;
    end else if (i_addr == ADDR_OEM_CFG1) begin
      next_rdata = oem_config_reg1;
    end else if (i_addr == ADDR_OEM_MODE) begin
      next_rdata = {7'h00, oem_mode};
    end
  end

  // Read data stand for the one cycle after the strobe
  // and fall back to zero after it, so a stale byte is never taken
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

//--- src/adcms_pkg.sv
// Purpose: Shared constants and carriers for the monitor converter sequencer
// Assumes: 50 MHz clock, byte-wide register port with a page bit
// Notes: Analog page in 9'h0xx, OEM configuration page in 9'h1xx
package adcms_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int NS_PER_US = 1000;

  // Register port widths
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // Analog page map
  localparam logic [8:0] ADDR_CAL_FIRST = 9'h038;
  localparam logic [8:0] ADDR_CAL_LAST = 9'h05B;
  localparam int CAL_BYTES = 36;
  localparam logic [8:0] ADDR_RESULT_FIRST = 9'h060;
  localparam logic [8:0] ADDR_RESULT_LAST = 9'h069;
  localparam logic [8:0] ADDR_DATA_READY = 9'h0FE;

  // OEM configuration page map
  localparam logic [8:0] ADDR_OEM_CFG0 = 9'h100;
  localparam logic [8:0] ADDR_OEM_CFG1 = 9'h101;
  localparam logic [8:0] ADDR_OEM_MODE = 9'h1F0;

  // Field positions and reset values
  localparam int AUX_SEL_LSB = 0;
  localparam int AUX_SEL_W = 3;
  localparam int BIAS_REF_BIT = 0;
  localparam int OEM_MODE_BIT = 0;
  localparam logic [7:0] OEM_CFG0_RESET = 8'h00;
  localparam logic [7:0] OEM_CFG1_RESET = 8'h00;
  localparam logic [7:0] LOW_BYTE_ZERO = 8'h00;

  // Number of monitored channels
  localparam int NUM_CHAN = 5;

  // Channel slots in conversion order; slot index times two is the result offset
  typedef enum logic [2:0] {
    CHAN_TEMP   = 3'b000,
    CHAN_SUPPLY = 3'b001,
    CHAN_BIAS   = 3'b010,
    CHAN_TXP    = 3'b011,
    CHAN_RXP    = 3'b100
  } adcms_chan_e;

  // Voltage slot sources
  typedef enum logic [2:0] {
    AUX_INPUT_SUPPLY = 3'b000,
    AUX_ANALOG_SUPPLY = 3'b001,
    AUX_BIAS_OUT = 3'b010,
    AUX_MOD_OUT = 3'b011,
    AUX_BIAS_DAC = 3'b100,
    AUX_MOD_DAC = 3'b101,
    AUX_FAULT_DAC = 3'b110
  } adcms_aux_e;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_START = 2'b01,
    SEQ_WAIT  = 2'b10
  } adcms_seq_e;

  // Request to the analog front end
  typedef struct packed {
    logic start;
    adcms_chan_e chan;
    adcms_aux_e aux;
    logic ref_to_supply;
  } adcms_conv_req_s;

  // Answer from the analog front end
  typedef struct packed {
    logic done;
    logic [7:0] code;
  } adcms_conv_rsp_s;

endpackage

//--- src/adcms_tick_gen.sv
// Purpose: Divider that marks the start of each conversion interval
// Assumes: Single clock, synchronous active-high reset
// Notes: Pulse lasts one cycle every PERIOD_CYCLES cycles
`timescale 1ns/10ps
`default_nettype none
module adcms_tick_gen #(
  parameter int PERIOD_CYCLES = 5000
) (
  input wire logic i_clock,
  input wire logic i_rst,
  output logic o_tick
);
  import adcms_pkg::*;

  localparam int CNT_W = $clog2(PERIOD_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_tick;

  // Count up through the interval and fire on wrap
  always_comb begin
    next_tick = 1'b0;
    next_count = count + CNT_ONE;
    if (count == CNT_LAST) begin
      next_count = CNT_ZERO;
      next_tick = 1'b1;
    end
  end

  // Register the divider
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count <= CNT_ZERO;
      o_tick <= 1'b0;
    end else begin
      count <= next_count;
      o_tick <= next_tick;
    end
  end

endmodule
`default_nettype wire

//--- verif/adcms_checker.sv
// Purpose: Port checker for the monitor converter sequencer
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the sequencer from the bench top file
`timescale 1ns/10ps
`default_nettype none
module adcms_checker
  import adcms_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [adcms_pkg::ADDR_W-1:0] i_addr,
  input wire logic [adcms_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [adcms_pkg::DATA_W-1:0] o_rdata,
  input wire adcms_pkg::adcms_conv_req_s o_conv_req,
  input wire adcms_pkg::adcms_conv_rsp_s i_conv_rsp,
  input wire logic [adcms_pkg::NUM_CHAN-1:0] o_data_ready
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  // Steps of one slot: answer, then the next request two cycles on
  sequence s_done;
    i_conv_rsp.done && o_conv_req.chan != CHAN_RXP;
  endsequence
  sequence s_next;
    ##2 o_conv_req.start && o_conv_req.chan == adcms_chan_e'($past(o_conv_req.chan, 2) + 3'h1);
  endsequence
  // Assertions on the register port and the converter link
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside its slot");
  start_pulse_a: assert property (o_conv_req.start |=> !o_conv_req.start)
    else $error("start longer than one cycle");
  chan_order_a: assert property (s_done |-> s_next)
    else $error("next channel not started in order");
  fields_hold_a: assert property (!o_conv_req.start |-> $stable(o_conv_req.chan) && $stable(o_conv_req.aux)
    && $stable(o_conv_req.ref_to_supply))
    else $error("request fields moved between starts");
  first_start_a: assert property ($fell(i_rst) |-> ##[1:3] o_conv_req.start)
    else $error("no start after reset");
  ready_set_a: assert property (i_conv_rsp.done |=> o_data_ready[$past(o_conv_req.chan)])
    else $error("flag not set by new result");
  ready_clear_a: assert property (i_rd && i_addr == ADDR_DATA_READY && !i_conv_rsp.done
    |=> o_data_ready == 5'h00)
    else $error("flags not cleared by read");
  ready_read_a: assert property (i_rd && i_addr == ADDR_DATA_READY
    |=> o_rdata == {3'h0, $past(o_data_ready)})
    else $error("flag byte wrong");
  low_byte_a: assert property (i_rd && i_addr >= ADDR_RESULT_FIRST && i_addr <= ADDR_RESULT_LAST
    && i_addr[0] |=> o_rdata == 8'h00)
    else $error("result low byte not zero");
  aux_range_a: assert property (o_conv_req.aux != 3'h7)
    else $error("unknown voltage node requested");
endmodule
`default_nettype wire

//--- verif/adcms_fe_model.sv
// Purpose: Behavioural analog front end for the sequencer
// Assumes: One answer per start, prompt and slow in turn
// Notes: Code names channel, node and reference so results can be traced
`timescale 1ns/10ps
`default_nettype none
module adcms_fe_model
  import adcms_pkg::*;
#(
  parameter int SLOW = 9
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire adcms_pkg::adcms_conv_req_s i_req,
  output var adcms_pkg::adcms_conv_rsp_s o_rsp
);
  int cnt;
  logic busy;
  logic slow;
  ////////////////////////////////////////
  // Code line toggles outside the answer so stale values never pass
  always_ff @(posedge i_clock) begin
    o_rsp.done <= 1'b0;
    o_rsp.code <= ~o_rsp.code;
    if (i_rst) begin
      busy <= 1'b0;
      slow <= 1'b0;
      cnt <= 0;
      o_rsp.code <= 8'h00;
    end else if (i_req.start) begin
      busy <= 1'b1;
      slow <= ~slow;
      cnt <= slow ? SLOW : 0;
    end else if (busy && cnt == 0) begin
      busy <= 1'b0;
      o_rsp.done <= 1'b1;
      o_rsp.code <= {1'b1, i_req.chan, (i_req.chan == CHAN_SUPPLY) ? i_req.aux : 3'h0,
                     (i_req.chan == CHAN_TXP) ? i_req.ref_to_supply : 1'b0};
    end else if (busy) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

//--- verif/adc_monitor_sequencer_test.sv
// Purpose: Self-checking bench for the monitor converter sequencer
// Assumes: Short conversion interval of 100 cycles
// Notes: Expected codes follow the front end model's encoding
`timescale 1ns/10ps
`default_nettype none
module adc_monitor_sequencer_test;
  import adcms_pkg::*;
  logic i_clock;
  logic i_rst;
  logic i_wr;
  logic i_rd;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic [DATA_W-1:0] o_rdata;
  adcms_conv_req_s o_conv_req;
  adcms_conv_rsp_s i_conv_rsp;
  logic [NUM_CHAN-1:0] o_data_ready;
  int n_mismatch = 0;
  int n_checks = 0;
  // Host calibration layout; plain defaults for where the words sit
  localparam logic [8:0] CAL_VT_FIRST = 9'h054;
  localparam int CAL_VT_BYTES = 8;
  localparam logic [8:0] CAL_BIAS_OFS = 9'h04E;
  localparam logic [7:0] UNITY_SLOPE_HI = 8'h01;
  localparam logic [7:0] BIAS_HI = {1'b1, CHAN_BIAS, 3'h0, 1'b0};
  localparam logic [15:0] BIAS_OFS = 16'h0000 - {BIAS_HI, LOW_BYTE_ZERO};
  ////////////////////////////////////////
  // Design and front end
  adcms_sequencer #(.CONV_INTERVAL_US(2)) adcms_sequencer_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_conv_req(o_conv_req), .i_conv_rsp(i_conv_rsp), .o_data_ready(o_data_ready));
  adcms_fe_model adcms_fe_model_i (.i_clock(i_clock), .i_rst(i_rst), .i_req(o_conv_req),
    .o_rsp(i_conv_rsp));
  // Clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  // Verdict and helpers
  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    check(o_rdata, exp);
  endtask
  // Bounded wait for a start of channel c, or for an answer
  task automatic wait_ev(input logic want_done, input adcms_chan_e c);
    int t;
    for (t = 0; t < 600; t++) begin
      @(negedge i_clock);
      if (want_done ? i_conv_rsp.done === 1'b1
          : (o_conv_req.start === 1'b1 && o_conv_req.chan === c)) break;
    end
    if (t == 600) begin
      n_mismatch++;
      $display("MISMATCH %0t wait ran out", $time);
      print_verdict();
    end
  endtask
  // A whole round that began after the last setting change
  task automatic wait_round();
    wait_ev(1'b0, CHAN_TEMP);
    wait_ev(1'b0, CHAN_RXP);
    wait_ev(1'b1, CHAN_RXP);
  endtask
  task automatic check_results(input logic [2:0] aux, input logic rf);
    logic [7:0] e;
    for (int c = 0; c < NUM_CHAN; c++) begin
      e = {1'b1, 3'(c), (c == 1) ? aux : 3'h0, (c == 3) ? rf : 1'b0};
      rd(ADDR_RESULT_FIRST + 9'(2 * c), e);
      rd(ADDR_RESULT_FIRST + 9'(2 * c + 1), LOW_BYTE_ZERO);
    end
  endtask
  // Main sequence
  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 9'h000;
    i_wdata = 8'h00;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(ADDR_OEM_CFG0, OEM_CFG0_RESET);
    rd(ADDR_OEM_CFG1, OEM_CFG1_RESET);
    wr(ADDR_OEM_CFG0, 8'h04);
    wr(ADDR_OEM_CFG1, 8'h01);
    wait_round();
    check_results(3'h0, 1'b1);
    rd(ADDR_DATA_READY, 8'h1F);
    rd(ADDR_DATA_READY, 8'h00);
    rd(9'h06A, 8'h00);
    wr(ADDR_RESULT_FIRST, 8'h55);
    rd(ADDR_RESULT_FIRST, 8'h80);
    wr(ADDR_OEM_MODE, 8'h01);
    wr(ADDR_CAL_FIRST, 8'h5A);
    rd(ADDR_CAL_FIRST, 8'h5A);
    wr(ADDR_OEM_MODE, 8'h00);
    wr(ADDR_CAL_FIRST, 8'hC3);
    rd(ADDR_CAL_FIRST, 8'h5A);
    wr(ADDR_OEM_MODE, 8'h01);
    // Every node code, then code 111 which falls back to the input supply
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_OEM_CFG0, 8'(k));
      wr(ADDR_OEM_CFG1, 8'(k % 2));
      wait_round();
      check_results((k == 7) ? 3'(AUX_INPUT_SUPPLY) : 3'(k), 1'(k % 2));
    end
    // Host keeps unity slopes and zero offsets for voltage and temperature
    for (int b = 0; b < CAL_VT_BYTES; b++) begin
      wr(CAL_VT_FIRST + 9'(b), (b % 4 == 0) ? UNITY_SLOPE_HI : 8'h00);
    end
    for (int b = 0; b < CAL_VT_BYTES; b++) begin
      rd(CAL_VT_FIRST + 9'(b), (b % 4 == 0) ? UNITY_SLOPE_HI : 8'h00);
    end
    // Host reads the bias result and keeps its negative as the offset
    rd(ADDR_RESULT_FIRST + 9'(2 * CHAN_BIAS), BIAS_HI);
    wr(CAL_BIAS_OFS, BIAS_OFS[15:8]);
    wr(CAL_BIAS_OFS + 9'h001, BIAS_OFS[7:0]);
    rd(CAL_BIAS_OFS, BIAS_OFS[15:8]);
    rd(CAL_BIAS_OFS + 9'h001, BIAS_OFS[7:0]);
    print_verdict();
  end
endmodule
bind adcms_sequencer adcms_checker adcms_checker_i (.i_clock(i_clock), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_conv_req(o_conv_req), .i_conv_rsp(i_conv_rsp), .o_data_ready(o_data_ready));
`default_nettype wire
